// ---- prm_board_model.sv ----
// prm_board_model: board circuitry on W pin lines, resolving each pin level
// assumes the bench supplies an external level and a drive enable per line
`timescale 1ns/1ps
`default_nettype none

module prm_board_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pins_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] pullup_in,
  input  wire logic [W-1:0] ext_val_in,
  input  wire logic [W-1:0] ext_en_in,
  output logic      [W-1:0] level_out
);
  // driven line shows its latch, else board drive, pull-up, or inverse of drive
  assign level_out = (oe_in & pins_in)
                   | (~oe_in & ext_en_in & ext_val_in)
                   | (~oe_in & ~ext_en_in & (pullup_in | ~pins_in));
endmodule

`default_nettype wire

// ---- prm_pin_remap_top.sv ----
// prm_pin_remap_top: pin remapping, port registers, bit ops and port a wake-up
// assumes all pin and peripheral inputs are synchronous to clock_in
//
// Contract
// R1 - peripheral output beats plain port output
// R2 - two remap select registers exist
// R3 - spi_out_loc: port_c_line_2 or port_a_line_2
// R4 - spi_in_i2c_data_loc: port_c_line_3 or port_a_line_3
// R5 - serial_clock_loc: port_c_line_4 or port_b_line_6
// R6 - spi_select_loc: port_a_line_1 or port_b_line_5
// R7 - ext_irq1_loc: port_b_line_1 or port_c_line_5
// R8 - timer1_clk_in_loc: port_a_line_4 or port_a_line_6
// R9 - timer0_clk_in_loc: port_b_line_2 or port_a_line_5
// R10 - uart_tx_loc: port_c_line_6 or port_b_line_3
// R11 - uart_rx_loc: port_c_line_5 or port_b_line_4
// R12 - unused remap bits ignore writes, read zero
// R13 - reset sets data and direction bits
// R14 - new output drives high from reset latch
// R15 - bit op reads port, rewrites byte
// R16 - falling enabled port a line wakes
// R17 - wake-up enable is per line
// R18 - direction one input, zero output
// R19 - output line reads back data latch
// R20 - pull-high enables when set, resets zero
// R21 - wake-up enable resets zero, one enables
// R22 - ext_irq0_loc picks between two lines
// R23 - remap change routes next cycle
`timescale 1ns/1ps
`default_nettype none

module prm_pin_remap_top (
  input  wire logic                     clock_in,
  input  wire logic                     srst_in,
  input  wire logic [7:0]               avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic      [31:0]              avs_readdata_out,
  output logic                          avs_waitrequest_out,
  input  wire logic [7:0]               port_a_pins_in,
  input  wire logic [6:0]               port_b_pins_in,
  input  wire logic [6:0]               port_c_pins_in,
  output logic      [7:0]               port_a_pins_out,
  output logic      [6:0]               port_b_pins_out,
  output logic      [6:0]               port_c_pins_out,
  output logic      [7:0]               port_a_pins_oe_out,
  output logic      [6:0]               port_b_pins_oe_out,
  output logic      [6:0]               port_c_pins_oe_out,
  output logic      [7:0]               port_a_pullup_out,
  output logic      [6:0]               port_b_pullup_out,
  output logic      [6:0]               port_c_pullup_out,
  input  wire prm_pkg::prm_periph_out_t periph_drive_in,
  output prm_pkg::prm_periph_in_t       periph_sense_out,
  input  wire logic                     sleep_in,
  output logic                          wake_out
);

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  logic [7:0]                  first_remap_r,  first_remap_nxt;
  logic [7:0]                  second_remap_r, second_remap_nxt;
  logic [2:0][7:0]             data_r,   data_nxt;
  logic [2:0][7:0]             dir_r,    dir_nxt;
  logic [2:0][7:0]             pullup_r, pullup_nxt;
  logic [7:0]                  wakeup_r, wakeup_nxt;
  logic                        ack_r,    ack_nxt;
  logic [31:0]                 rdata_r,  rdata_nxt;
  logic [7:0]                  pa_prev_r, pa_prev_nxt;
  logic                        wake_r,   wake_nxt;
  logic [2:0][7:0]             pin_out_r, pin_out_nxt;
  logic [2:0][7:0]             pin_oe_r,  pin_oe_nxt;
  prm_pkg::prm_periph_in_t     sense_r,   sense_nxt;
  logic [2:0][7:0]             pin_in;
  logic [2:0][7:0]             port_rd;
  logic [2:0][7:0]             port_mask;
  logic                        req;
  logic                        commit;
  logic                        wr_commit;
  logic [1:0]                  bop_port;
  logic [7:0]                  bop_bit;
  logic [7:0]                  bop_cur;
  logic [7:0]                  bop_new;

  // -------------------------------------------------------------------------
  // pin gathering and port read view
  // -------------------------------------------------------------------------
  // port b and c have no line 7; it reads as zero
  assign port_mask = {prm_pkg::PORT_BC_MASK, prm_pkg::PORT_BC_MASK, prm_pkg::PORT_A_MASK};
  assign pin_in    = {1'b0, port_c_pins_in, 1'b0, port_b_pins_in, port_a_pins_in};

  // input lines read the pin, output lines read the latch
  always_comb begin
    for (int p = 0; p < prm_pkg::NUM_PORTS; p++) begin
      port_rd[p] = ((dir_r[p] & pin_in[p]) | (~dir_r[p] & data_r[p])) & port_mask[p]; // [R19] [R18]
    end
  end

  // -------------------------------------------------------------------------
  // avalon-mm slave: one wait state, then the access completes
  // -------------------------------------------------------------------------
  assign req                 = avs_read_in | avs_write_in;
  assign commit              = req & ack_r;
  assign wr_commit           = commit & avs_write_in & avs_byteenable_in[0];
  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out    = rdata_r;

  // bit-op command decode
  assign bop_port = avs_writedata_in[prm_pkg::BOP_PORT_LSB +: 2];
  assign bop_bit  = 8'h01 << avs_writedata_in[2:0];

  always_comb begin
    bop_cur = 8'h00;
    if (bop_port < 2'h3) begin
      bop_cur = avs_writedata_in[prm_pkg::BOP_TARGET_BIT] ? dir_r[bop_port] : port_rd[bop_port];
    end
    bop_new = avs_writedata_in[prm_pkg::BOP_VALUE_BIT] ? (bop_cur | bop_bit) : (bop_cur & ~bop_bit);
  end

  // bus handshake and read data capture in the wait cycle
  always_comb begin
    ack_nxt   = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read_in && !ack_r) begin
      rdata_nxt = 32'h0000_0000; // unmapped addresses read zero
      for (int p = 0; p < prm_pkg::NUM_PORTS; p++) begin
        if (avs_address_in == prm_pkg::OFS_PORT_DATA + 8'(4 * p)) begin
          rdata_nxt[7:0] = port_rd[p];
        end
        if (avs_address_in == prm_pkg::OFS_PORT_DIR + 8'(4 * p)) begin
          rdata_nxt[7:0] = dir_r[p];
        end
        if (avs_address_in == prm_pkg::OFS_PORT_PULLUP + 8'(4 * p)) begin
          rdata_nxt[7:0] = pullup_r[p];
        end
      end
      if (avs_address_in == prm_pkg::OFS_FIRST_REMAP) begin
        rdata_nxt[7:0] = first_remap_r;
      end
      if (avs_address_in == prm_pkg::OFS_SECOND_REMAP) begin
        rdata_nxt[7:0] = second_remap_r;
      end
      if (avs_address_in == prm_pkg::OFS_WAKEUP) begin
        rdata_nxt[7:0] = wakeup_r;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------------------
  // writes land on the edge that completes the access
  always_comb begin
    first_remap_nxt  = first_remap_r;
    second_remap_nxt = second_remap_r;
    data_nxt         = data_r;
    dir_nxt          = dir_r;
    pullup_nxt       = pullup_r;
    wakeup_nxt       = wakeup_r;
    if (wr_commit) begin
      if (avs_address_in == prm_pkg::OFS_FIRST_REMAP) begin
        first_remap_nxt = avs_writedata_in[7:0] & prm_pkg::FIRST_REMAP_MASK; // [R2] [R12] [R23]
      end
      if (avs_address_in == prm_pkg::OFS_SECOND_REMAP) begin
        second_remap_nxt = avs_writedata_in[7:0] & prm_pkg::SECOND_REMAP_MASK; // [R2] [R12]
      end
      if (avs_address_in == prm_pkg::OFS_WAKEUP) begin
        wakeup_nxt = avs_writedata_in[7:0]; // [R17] [R21]
      end
      for (int p = 0; p < prm_pkg::NUM_PORTS; p++) begin
        if (avs_address_in == prm_pkg::OFS_PORT_DATA + 8'(4 * p)) begin
          data_nxt[p] = avs_writedata_in[7:0] & port_mask[p];
        end
        if (avs_address_in == prm_pkg::OFS_PORT_DIR + 8'(4 * p)) begin
          dir_nxt[p] = avs_writedata_in[7:0] & port_mask[p];
        end
        if (avs_address_in == prm_pkg::OFS_PORT_PULLUP + 8'(4 * p)) begin
          pullup_nxt[p] = avs_writedata_in[7:0] & port_mask[p]; // [R20]
        end
      end
      // whole port read, one bit changed, full byte written back
      if (avs_address_in == prm_pkg::OFS_BIT_OP && bop_port < 2'h3) begin
        if (avs_writedata_in[prm_pkg::BOP_TARGET_BIT]) begin
          dir_nxt[bop_port] = bop_new & port_mask[bop_port]; // [R15]
        end else begin
          data_nxt[bop_port] = bop_new & port_mask[bop_port]; // [R15]
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      first_remap_r  <= prm_pkg::REMAP_RST;
      second_remap_r <= prm_pkg::REMAP_RST;
      data_r         <= {prm_pkg::PORT_BC_MASK, prm_pkg::PORT_BC_MASK,
                         prm_pkg::PORT_A_MASK}; // [R13]
      dir_r          <= {prm_pkg::PORT_BC_MASK, prm_pkg::PORT_BC_MASK,
                         prm_pkg::PORT_A_MASK}; // [R13]
      pullup_r       <= {3{prm_pkg::PULLUP_RST}}; // [R20]
      wakeup_r       <= prm_pkg::WAKEUP_RST; // [R21]
    end else begin
      first_remap_r  <= first_remap_nxt;
      second_remap_r <= second_remap_nxt;
      data_r         <= data_nxt;
      dir_r          <= dir_nxt;
      pullup_r       <= pullup_nxt;
      wakeup_r       <= wakeup_nxt;
    end
  end

  // pull-high acts only on lines set as inputs
  assign port_a_pullup_out = pullup_r[0] & dir_r[0];
  assign port_b_pullup_out = pullup_r[1][6:0] & dir_r[1][6:0];
  assign port_c_pullup_out = pullup_r[2][6:0] & dir_r[2][6:0];

  // -------------------------------------------------------------------------
  // pin routing
  // -------------------------------------------------------------------------
  // plain port drive first, then enabled peripheral outputs override it
  always_comb begin
    pin_out_nxt = data_r; // [R14]
    pin_oe_nxt  = ~dir_r & port_mask; // [R18]
    if (periph_drive_in.sdo_en) begin // [R1]
      if (first_remap_r[prm_pkg::SPI_OUT_LOC_BIT]) begin // [R3]
        pin_out_nxt[0][2] = periph_drive_in.sdo;
        pin_oe_nxt[0][2]  = 1'b1;
      end else begin
        pin_out_nxt[2][2] = periph_drive_in.sdo;
        pin_oe_nxt[2][2]  = 1'b1;
      end
    end
    if (periph_drive_in.sda_en) begin // [R1]
      if (first_remap_r[prm_pkg::SPI_IN_I2C_DATA_LOC_BIT]) begin // [R4]
        pin_out_nxt[0][3] = periph_drive_in.sda_o;
        pin_oe_nxt[0][3]  = 1'b1;
      end else begin
        pin_out_nxt[2][3] = periph_drive_in.sda_o;
        pin_oe_nxt[2][3]  = 1'b1;
      end
    end
    if (periph_drive_in.sck_en) begin // [R1]
      if (first_remap_r[prm_pkg::SERIAL_CLOCK_LOC_BIT]) begin // [R5]
        pin_out_nxt[1][6] = periph_drive_in.sck_o;
        pin_oe_nxt[1][6]  = 1'b1;
      end else begin
        pin_out_nxt[2][4] = periph_drive_in.sck_o;
        pin_oe_nxt[2][4]  = 1'b1;
      end
    end
    if (periph_drive_in.scs_en) begin // [R1]
      if (first_remap_r[prm_pkg::SPI_SELECT_LOC_BIT]) begin // [R6]
        pin_out_nxt[1][5] = periph_drive_in.scs_o;
        pin_oe_nxt[1][5]  = 1'b1;
      end else begin
        pin_out_nxt[0][1] = periph_drive_in.scs_o;
        pin_oe_nxt[0][1]  = 1'b1;
      end
    end
    if (periph_drive_in.tx_en) begin // [R1]
      if (second_remap_r[prm_pkg::UART_TX_LOC_BIT]) begin // [R10]
        pin_out_nxt[1][3] = periph_drive_in.tx;
        pin_oe_nxt[1][3]  = 1'b1;
      end else begin
        pin_out_nxt[2][6] = periph_drive_in.tx;
        pin_oe_nxt[2][6]  = 1'b1;
      end
    end
  end

  // peripheral inputs follow the selected line
  always_comb begin
    sense_nxt.sdi_sda = first_remap_r[prm_pkg::SPI_IN_I2C_DATA_LOC_BIT] ?
                        pin_in[0][3] : pin_in[2][3]; // [R4]
    sense_nxt.sck     = first_remap_r[prm_pkg::SERIAL_CLOCK_LOC_BIT] ?
                        pin_in[1][6] : pin_in[2][4]; // [R5]
    sense_nxt.scs     = first_remap_r[prm_pkg::SPI_SELECT_LOC_BIT] ?
                        pin_in[1][5] : pin_in[0][1]; // [R6]
    sense_nxt.ext_irq_one  = first_remap_r[prm_pkg::EXT_IRQ1_LOC_BIT] ?
                             pin_in[2][5] : pin_in[1][1]; // [R7]
    sense_nxt.ext_irq_zero = first_remap_r[prm_pkg::EXT_IRQ0_LOC_BIT] ?
                             pin_in[2][0] : pin_in[1][0]; // [R22]
    sense_nxt.timer_one_clk_in  = second_remap_r[prm_pkg::TIMER1_CLK_IN_LOC_BIT] ?
                                  pin_in[0][6] : pin_in[0][4]; // [R8]
    sense_nxt.timer_zero_clk_in = second_remap_r[prm_pkg::TIMER0_CLK_IN_LOC_BIT] ?
                                  pin_in[0][5] : pin_in[1][2]; // [R9]
    sense_nxt.rx      = second_remap_r[prm_pkg::UART_RX_LOC_BIT] ?
                        pin_in[1][4] : pin_in[2][5]; // [R11]
  end

  // registered routing: a remap write shows on the pins one cycle later
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      sense_r   <= '0;
    end else begin
      pin_out_r <= pin_out_nxt & port_mask; // [R23]
      pin_oe_r  <= pin_oe_nxt & port_mask;
      sense_r   <= sense_nxt;
    end
  end

  assign port_a_pins_out    = pin_out_r[0];
  assign port_b_pins_out    = pin_out_r[1][6:0];
  assign port_c_pins_out    = pin_out_r[2][6:0];
  assign port_a_pins_oe_out = pin_oe_r[0];
  assign port_b_pins_oe_out = pin_oe_r[1][6:0];
  assign port_c_pins_oe_out = pin_oe_r[2][6:0];
  assign periph_sense_out   = sense_r;

  // -------------------------------------------------------------------------
  // port a wake-up
  // -------------------------------------------------------------------------
  // a high-to-low step on any enabled line while asleep gives one pulse
  always_comb begin
    pa_prev_nxt = port_a_pins_in;
    wake_nxt    = sleep_in & (|(pa_prev_r & ~port_a_pins_in & wakeup_r)); // [R16] [R17]
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pa_prev_r <= 8'hff;
      wake_r    <= 1'b0;
    end else begin
      pa_prev_r <= pa_prev_nxt;
      wake_r    <= wake_nxt;
    end
  end

  assign wake_out = wake_r;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  chk_reset_port_state: assert property (@(posedge clock_in) disable iff (srst_in) // [R13]
    $fell(srst_in) |-> (dir_r[0] == 8'hff && data_r[0] == 8'hff && wakeup_r == 8'h00))
    else $error("port state wrong after reset");

  chk_fresh_output_high: assert property (@(posedge clock_in) disable iff (srst_in) // [R14]
    ($fell(dir_r[0][0]) && data_r[0][0]) |=> (port_a_pins_out[0] && port_a_pins_oe_out[0]))
    else $error("new output line does not drive high");

  chk_input_no_drive: assert property (@(posedge clock_in) disable iff (srst_in) // [R18]
    dir_r[0][7] |=> !port_a_pins_oe_out[7])
    else $error("input line is driven");

  chk_sdo_alt_route: assert property (@(posedge clock_in) disable iff (srst_in) // [R3]
    (periph_drive_in.sdo_en && first_remap_r[5]) |=>
      (port_a_pins_oe_out[2] && port_a_pins_out[2] == $past(periph_drive_in.sdo)))
    else $error("serial data out not on alternate line");

  chk_sck_alt_sense: assert property (@(posedge clock_in) disable iff (srst_in) // [R5]
    first_remap_r[3] |=> periph_sense_out.sck == $past(port_b_pins_in[6]))
    else $error("serial clock not taken from alternate line");

  chk_rx_default: assert property (@(posedge clock_in) disable iff (srst_in) // [R11]
    !second_remap_r[0] |=> periph_sense_out.rx == $past(port_c_pins_in[5]))
    else $error("receive not taken from default line");

  chk_remap_upper_zero: assert property (@(posedge clock_in) disable iff (srst_in) // [R12]
    (commit && avs_read_in && avs_address_in == prm_pkg::OFS_SECOND_REMAP) |->
      avs_readdata_out[7:4] == 4'h0)
    else $error("unused remap bits read nonzero");

  chk_remap_takes_effect: assert property (@(posedge clock_in) disable iff (srst_in) // [R23]
    (wr_commit && avs_address_in == prm_pkg::OFS_FIRST_REMAP) |=>
      first_remap_r == ($past(avs_writedata_in[7:0]) & 8'h3f))
    else $error("remap write not applied");

  chk_bit_op_one_bit: assert property (@(posedge clock_in) disable iff (srst_in) // [R15]
    (wr_commit && avs_address_in == prm_pkg::OFS_BIT_OP && avs_writedata_in[4:3] == 2'h0
     && !avs_writedata_in[5]) |=>
      ((data_r[0] ^ $past(port_rd[0])) & ~(8'h01 << $past(avs_writedata_in[2:0]))) == 8'h00)
    else $error("bit op changed another bit");

  chk_wake_on_fall: assert property (@(posedge clock_in) disable iff (srst_in) // [R16]
    (sleep_in && |($past(port_a_pins_in) & ~port_a_pins_in & wakeup_r)) |=> wake_out)
    else $error("missed port a wake-up");

endmodule

`default_nettype wire

// ---- prm_pkg.sv ----
// prm_pkg: shared constants and carriers for the pin remap and port block
// assumes an 8-bit byte address on an avalon-mm slave, one word per register
`default_nettype none

package prm_pkg;

  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_FIRST_REMAP  = 8'h00;
  localparam logic [7:0] OFS_SECOND_REMAP = 8'h04;
  localparam logic [7:0] OFS_PORT_DATA    = 8'h08; // data a,b,c at +0,+4,+8
  localparam logic [7:0] OFS_PORT_DIR     = 8'h14; // direction a,b,c
  localparam logic [7:0] OFS_PORT_PULLUP  = 8'h20; // pull-high a,b,c
  localparam logic [7:0] OFS_WAKEUP       = 8'h2c;
  localparam logic [7:0] OFS_BIT_OP       = 8'h30;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int SPI_OUT_LOC_BIT         = 5;
  localparam int SPI_IN_I2C_DATA_LOC_BIT = 4;
  localparam int SERIAL_CLOCK_LOC_BIT    = 3;
  localparam int SPI_SELECT_LOC_BIT      = 2;
  localparam int EXT_IRQ1_LOC_BIT        = 1;
  localparam int EXT_IRQ0_LOC_BIT        = 0;
  localparam int TIMER1_CLK_IN_LOC_BIT   = 3;
  localparam int TIMER0_CLK_IN_LOC_BIT   = 2;
  localparam int UART_TX_LOC_BIT         = 1;
  localparam int UART_RX_LOC_BIT         = 0;
  // bit-op command: [2:0] line, [4:3] port, [5] 1=direction, [6] 1=set
  localparam int BOP_PORT_LSB   = 3;
  localparam int BOP_TARGET_BIT = 5;
  localparam int BOP_VALUE_BIT  = 6;

  // -------------------------------------------------------------------------
  // masks and reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] FIRST_REMAP_MASK  = 8'h3f;
  localparam logic [7:0] SECOND_REMAP_MASK = 8'h0f;
  localparam logic [7:0] REMAP_RST         = 8'h00;
  localparam logic [7:0] PORT_A_MASK       = 8'hff;
  localparam logic [7:0] PORT_BC_MASK      = 8'h7f;
  localparam logic [7:0] PULLUP_RST        = 8'h00;
  localparam logic [7:0] WAKEUP_RST        = 8'h00;
  localparam int         NUM_PORTS         = 3;

  // -------------------------------------------------------------------------
  // carriers between block and peripherals
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic sdo;       // serial data out
    logic sdo_en;
    logic sda_o;     // shared sdi/sda line drive
    logic sda_en;
    logic sck_o;     // shared sck/scl line drive
    logic sck_en;
    logic scs_o;     // chip select drive
    logic scs_en;
    logic tx;        // async transmit
    logic tx_en;
  } prm_periph_out_t;

  typedef struct packed {
    logic sdi_sda;
    logic sck;
    logic scs;
    logic ext_irq_one;
    logic ext_irq_zero;
    logic timer_one_clk_in;
    logic timer_zero_clk_in;
    logic rx;
  } prm_periph_in_t;

endpackage

`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for the pin remap and port block
// assumes one 10 mhz clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock_in, srst_in, rd, wr, ws, sleep, wake;
  logic [7:0] adr;
  logic [31:0] wd, rdd, q;
  logic [21:0] pout, poe, ppu, plev, ext_v, ext_e;
  prm_pkg::prm_periph_out_t drv;
  prm_pkg::prm_periph_in_t  sns;
  int bad_count, samples_checked, k;

  // ---------------------------------------------------------------------
  // clock, design and board
  // ---------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  prm_pin_remap_top dut (.clock_in(clock_in), .srst_in(srst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdd), .avs_waitrequest_out(ws), .port_a_pins_in(plev[7:0]),
    .port_b_pins_in(plev[14:8]), .port_c_pins_in(plev[21:15]), .port_a_pins_out(pout[7:0]),
    .port_b_pins_out(pout[14:8]), .port_c_pins_out(pout[21:15]),
    .port_a_pins_oe_out(poe[7:0]), .port_b_pins_oe_out(poe[14:8]),
    .port_c_pins_oe_out(poe[21:15]), .port_a_pullup_out(ppu[7:0]),
    .port_b_pullup_out(ppu[14:8]), .port_c_pullup_out(ppu[21:15]),
    .periph_drive_in(drv), .periph_sense_out(sns), .sleep_in(sleep), .wake_out(wake));
  prm_board_model #(.W(22)) board (.pins_in(pout), .oe_in(poe), .pullup_in(ppu),
    .ext_val_in(ext_v), .ext_en_in(ext_e), .level_out(plev));

  // ---------------------------------------------------------------------
  // checking, bus access and closing
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge clock_in);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clock_in);
      done = ~ws;
      q = rdd;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (!done) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  // checks one relocatable signal at its default and alternative line
  task automatic route(input int o, input int ofs, input int b, input int p, input int l0,
                       input int l1);
    logic g0, g1;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'(ofs), 8'(1 << b) & {8{s[0]}});
      if (o) begin
        drv <= prm_pkg::prm_periph_out_t'(10'h1 << p);
        tick(2);
        g0 = poe[l0] & ~pout[l0];
        g1 = poe[l1] & ~pout[l1];
      end else begin
        ext_v <= ~(22'h1 << l0);
        tick(2);
        g0 = sns[p];
        @(posedge clock_in);
        ext_v <= ~(22'h1 << l1);
        tick(2);
        g1 = sns[p];
      end
      chk("route", {g0, g1}, (s == 0) ^ (o != 0) ? 32'h1 : 32'h2);
    end
    bus(1'b1, 8'(ofs), 8'h00);
    drv <= '0;
    ext_v <= '1;
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    srst_in = 1'b1;
    {rd, wr, sleep, adr, wd} = '0;
    drv = '0;
    ext_v = '1;
    ext_e = '1;
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    rdc("remap_first", 8'h00, 8'h00);
    rdc("remap_second", 8'h04, 8'h00);
    rdc("data_a", 8'h08, 8'hff);
    rdc("dir_a", 8'h14, 8'hff);
    rdc("dir_c", 8'h1c, 8'h7f);
    rdc("pullup_a", 8'h20, 8'h00);
    rdc("wakeup", 8'h2c, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    bus(1'b1, 8'h00, 8'hff);
    rdc("remap_first_w", 8'h00, 8'h3f);
    bus(1'b1, 8'h04, 8'hff);
    rdc("remap_second_w", 8'h04, 8'h0f);
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    // outputs from the reset latch, then a bit clear
    bus(1'b1, 8'h14, 8'h00);
    tick(2);
    chk("oe_a", poe[7:0], 8'hff);
    chk("out_a", pout[7:0], 8'hff);
    bus(1'b1, 8'h30, 8'h03);
    rdc("bitop_a", 8'h08, 8'hf7);
    // bit set on an input port keeps pin levels of the other lines
    ext_v[14:8] <= 7'h55;
    bus(1'b1, 8'h30, 8'h49);
    bus(1'b1, 8'h18, 8'h00);
    rdc("bitop_b", 8'h0c, 8'h57);
    chk("out_b", pout[14:8], 7'h57);
    bus(1'b1, 8'h18, 8'h7f);
    bus(1'b1, 8'h14, 8'hff);
    ext_v <= '1;
    bus(1'b1, 8'h20, 8'h0f);
    tick(2);
    chk("pullup_pin", ppu[7:0], 8'h0f);
    // port c as outputs with latch high: a peripheral drive must win there
    bus(1'b1, 8'h1c, 8'h00);
    route(1, 0, 5, 8, 17, 2);
    route(1, 0, 4, 6, 18, 3);
    route(1, 0, 3, 4, 19, 14);
    route(1, 0, 2, 2, 1, 13);
    route(1, 4, 1, 0, 21, 11);
    bus(1'b1, 8'h1c, 8'h7f);
    route(0, 0, 4, 7, 18, 3);
    route(0, 0, 3, 6, 19, 14);
    route(0, 0, 2, 5, 1, 13);
    route(0, 0, 1, 4, 9, 20);
    route(0, 0, 0, 3, 8, 15);
    route(0, 4, 3, 2, 4, 6);
    route(0, 4, 2, 1, 10, 5);
    route(0, 4, 0, 0, 20, 12);
    // wake-up on an enabled line only
    bus(1'b1, 8'h2c, 8'h08);
    sleep <= 1'b1;
    ext_v[3] <= 1'b0;
    k = 0;
    repeat (5) begin
      @(negedge clock_in);
      k += int'(wake === 1'b1);
    end
    chk("wake_on", k, 1);
    @(posedge clock_in);
    ext_v[2] <= 1'b0;
    k = 0;
    repeat (5) begin
      @(negedge clock_in);
      k += int'(wake === 1'b1);
    end
    chk("wake_off", k, 0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
